// ==== verilog/sfr_feedback_readback.sv ====
`timescale 1ns/1ns
module sfr_feedback_readback
  import sfr_pkg::*;
(
  input  wire logic                          clk,             // 50 MHz system clock
  input  wire logic                          rstn,            // Async reset, active low
  input  wire logic                          calMode,         // Calibration mode active
  input  wire logic                          layoutSelect,    // feedback_layout_select
  input  wire logic                          ditherEnable,    // Dither on
  input  wire logic [NumChannels-1:0]        channelActive,   // Channel operating
  input  wire logic [NumChannels-1:0][15:0]  calCurrent,      // Calibration reading
  input  wire logic [NumChannels-1:0]        sampleValid,     // Current sample strobe
  input  wire logic [NumChannels-1:0][7:0]   currentSample,   // Current, 11.7 mA lsb
  input  wire logic [NumChannels-1:0]        cycleEnd,        // Switching cycle end pulse
  input  wire logic [NumChannels-1:0][11:0]  accumIn,         // current_accumulation
  input  wire logic [NumChannels-1:0]        ditherCycleEnd,  // Dither cycle end pulse
  input  wire logic                          rdReq,           // Read frame decoded
  input  wire logic [1:0]                    rdChannel,       // Channel from frame
  output logic      [31:0]                   rdData,          // Feedback word
  output logic                               rdValid          // Word valid, one cycle
);

  function automatic logic [7:0] maxOf(input logic [7:0] a, input logic [7:0] b);
    maxOf = (a > b) ? a : b;
  endfunction

  function automatic logic [7:0] minOf(input logic [7:0] a, input logic [7:0] b);
    minOf = (a < b) ? a : b;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Period time base

  logic [3:0] prescale_reg;
  logic       unitTick;

  assign unitTick = (prescale_reg == PrescaleLast);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      prescale_reg <= '0;
    end else begin
      prescale_reg <= prescale_reg + 4'h1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Per-channel switching cycle capture

  logic [NumChannels-1:0][11:0] periodCnt_reg;
  logic [NumChannels-1:0][11:0] periodHold_reg;
  logic [NumChannels-1:0][11:0] accumHold_reg;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      periodCnt_reg  <= '0;
      periodHold_reg <= '0;
      accumHold_reg  <= '0;
    end else begin
      for (int c = 0; c < NumChannels; c++) begin
        if (!channelActive[c]) begin
          periodCnt_reg[c] <= '0;
        end else if (cycleEnd[c]) begin
          periodHold_reg[c] <= periodCnt_reg[c];
          accumHold_reg[c]  <= accumIn[c];
          periodCnt_reg[c]  <= unitTick ? 12'h001 : 12'h000;
        end else if (unitTick && periodCnt_reg[c] != 12'hfff) begin
          periodCnt_reg[c] <= periodCnt_reg[c] + 12'h001;
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Max / min tracking and dither cycle count

  logic [NumChannels-1:0][7:0] maxRun_reg;
  logic [NumChannels-1:0][7:0] minRun_reg;
  logic [NumChannels-1:0][7:0] maxHold_reg;
  logic [NumChannels-1:0][7:0] minHold_reg;
  logic [NumChannels-1:0][7:0] swRun_reg;
  logic [NumChannels-1:0][7:0] swHold_reg;
  logic [NumChannels-1:0]      restart;

  // A read restarts tracking only when dither is off; a dither cycle end does only when dither is on
  always_comb begin
    for (int c = 0; c < NumChannels; c++) begin
      restart[c] = ditherEnable ? ditherCycleEnd[c]
                                : (rdReq && rdChannel == 2'(c));
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      maxRun_reg  <= '0;
      minRun_reg  <= {NumChannels{MinStart}};
      maxHold_reg <= '0;
      minHold_reg <= '0;
    end else begin
      for (int c = 0; c < NumChannels; c++) begin
        if (restart[c]) begin
          if (ditherEnable) begin
            maxHold_reg[c] <= maxRun_reg[c];
            minHold_reg[c] <= minRun_reg[c];
          end
          // Sample arriving with the restart seeds the new window, not lost
          maxRun_reg[c] <= sampleValid[c] ? currentSample[c] : MaxStart;
          minRun_reg[c] <= sampleValid[c] ? currentSample[c] : MinStart;
        end else if (sampleValid[c]) begin
          maxRun_reg[c] <= maxOf(maxRun_reg[c], currentSample[c]);
          minRun_reg[c] <= minOf(minRun_reg[c], currentSample[c]);
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      swRun_reg  <= '0;
      swHold_reg <= '0;
    end else begin
      for (int c = 0; c < NumChannels; c++) begin
        if (!ditherEnable) begin
          swRun_reg[c] <= '0;
        end else if (ditherCycleEnd[c]) begin
          // Saturate so a full count plus a coincident end cannot wrap to zero
          swHold_reg[c] <= (swRun_reg[c] == 8'hff) ? 8'hff
                         : swRun_reg[c] + {7'h00, cycleEnd[c]};
          swRun_reg[c]  <= '0;
        end else if (cycleEnd[c] && swRun_reg[c] != 8'hff) begin
          swRun_reg[c] <= swRun_reg[c] + 8'h01;
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read word assembly

  logic [31:0] word_next;
  logic [23:0] fields;
  logic        chanValid;

  always_comb begin
    chanValid = (rdChannel != 2'b11) && channelActive[rdChannel];
    fields    = '0;
    if (!chanValid) begin
      fields = '0;
    end else if (calMode) begin
      fields[CalLsb +: 16] = calCurrent[rdChannel];
    end else if (!layoutSelect) begin
      fields[AccumLsb +: 12]  = accumHold_reg[rdChannel];
      fields[PeriodLsb +: 12] = periodHold_reg[rdChannel];
    end else begin
      fields[MaxLsb +: 8] = ditherEnable ? maxHold_reg[rdChannel]
                                         : maxRun_reg[rdChannel];
      fields[MinLsb +: 8] = ditherEnable ? minHold_reg[rdChannel]
                                         : minRun_reg[rdChannel];
      fields[SwCountLsb +: 8] = ditherEnable ? swHold_reg[rdChannel] : 8'h00;
    end
    word_next                     = '0;
    word_next[RwFlagBit]          = 1'b0;
    word_next[CodeLsb +: 4]       = FeedbackCode;
    word_next[ChannelLsb +: 2]    = rdChannel;
    word_next[23:0]               = fields;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdData  <= FeedbackReset;
      rdValid <= 1'b0;
    end else begin
      rdValid <= rdReq;
      if (rdReq) begin
        rdData <= word_next;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Checks

  sequence s_tick;
    unitTick;
  endsequence

  sequence s_quiet15;
    !unitTick [*8] ##1 !unitTick [*7];
  endsequence

  property p_header;
    @(posedge clk) disable iff (!rstn)
      rdValid |-> rdData[31] == 1'b0 && rdData[30:27] == FeedbackCode && !rdData[26];
  endproperty
  a_header: assert property (p_header) else $error("Header bits wrong");

  property p_channel;
    @(posedge clk) disable iff (!rstn)
      rdReq |=> rdValid && rdData[25:24] == $past(rdChannel);
  endproperty
  a_channel: assert property (p_channel) else $error("Channel echo wrong");

  property p_cal;
    @(posedge clk) disable iff (!rstn)
      rdReq && calMode && chanValid |=> rdData[23:8] == $past(calCurrent[rdChannel]);
  endproperty
  a_cal: assert property (p_cal) else $error("Calibration field wrong");

  // Cycle end, one quiet cycle, then a normal-layout read of the same channel
  sequence s_endThenRead;
    (channelActive[1] && cycleEnd[1])
    ##1 (channelActive[1] && !cycleEnd[1])
    ##1 (rdReq && rdChannel == 2'b01 && !calMode && !layoutSelect && channelActive[1]
         && !cycleEnd[1]);
  endsequence

  property p_accum;
    @(posedge clk) disable iff (!rstn)
      s_endThenRead |=> rdData[23:12] == $past(accumIn[1], 3);
  endproperty
  a_accum: assert property (p_accum) else $error("Accumulation field wrong");

  property p_unit;
    @(posedge clk) disable iff (!rstn)
      s_tick |=> s_quiet15 ##1 s_tick;
  endproperty
  a_unit: assert property (p_unit) else $error("Period unit not 16 clocks");

  property p_maxRestart;
    @(posedge clk) disable iff (!rstn)
      rdReq && rdChannel == 2'b00 && !ditherEnable && !sampleValid[0]
      |=> maxRun_reg[0] == MaxStart && minRun_reg[0] == MinStart;
  endproperty
  a_maxRestart: assert property (p_maxRestart) else $error("Read did not restart");

  property p_maxTrack;
    @(posedge clk) disable iff (!rstn)
      sampleValid[0] && !restart[0] |=> maxRun_reg[0] >= $past(currentSample[0])
                                      && minRun_reg[0] <= $past(currentSample[0]);
  endproperty
  a_maxTrack: assert property (p_maxTrack) else $error("Extremes not tracked");

  property p_swZero;
    @(posedge clk) disable iff (!rstn)
      rdReq && !calMode && layoutSelect && !ditherEnable |=> rdData[7:0] == 8'h00;
  endproperty
  a_swZero: assert property (p_swZero) else $error("Cycle count not zero");

  property p_idle;
    @(posedge clk) disable iff (!rstn)
      rdReq && !chanValid |=> rdData[23:0] == 24'h000000;
  endproperty
  a_idle: assert property (p_idle) else $error("Idle channel not zero");

endmodule // sfr_feedback_readback

// ==== inc/sfr_pkg.sv ====
package sfr_pkg;
  localparam int          NumChannels    = 3;
  localparam int          ClkHz          = 50_000_000;
  localparam int          PeriodUnitClks = 16;
  localparam logic [31:0] FeedbackReset  = 32'h4000_0000;
  localparam logic [3:0]  FeedbackCode   = 4'h8;
  localparam int          RwFlagBit      = 31;
  localparam int          CodeLsb        = 27;
  localparam int          ChannelLsb     = 24;
  localparam int          CalLsb         = 8;
  localparam int          AccumLsb       = 12;
  localparam int          PeriodLsb      = 0;
  localparam int          MaxLsb         = 16;
  localparam int          MinLsb         = 8;
  localparam int          SwCountLsb     = 0;
  localparam logic [7:0]  MinStart       = 8'hff;
  localparam logic [7:0]  MaxStart       = 8'h00;
  localparam logic [3:0]  PrescaleLast   = 4'(PeriodUnitClks - 1);
endpackage

// ==== tb/sfr_host_model.sv ====
`timescale 1ns/1ns
module sfr_host_model (
  input  wire logic        clk,       // System clock
  input  wire logic        rdValid,   // Word valid pulse
  input  wire logic [31:0] rdData,    // Feedback word
  output logic             rdReq,     // Decoded read frame
  output logic [1:0]       rdChannel  // Channel field of frame
);
  initial begin
    rdReq = 1'b0;
    rdChannel = 2'h0;
  end
  ////////////////////////////////////////////////////////////////
  // One read frame; the word is taken one clock after the request
  task automatic read_word(input logic [1:0] ch, output logic [31:0] w, output logic pulseOk);
    @(posedge clk);
    #2;
    rdReq = 1'b1;
    rdChannel = ch;
    @(posedge clk);
    #2;
    rdReq = 1'b0;
    // Field is stale once taken, so do not leave the old code on it
    rdChannel = ~ch;
    w = rdData;
    pulseOk = (rdValid === 1'b1);
    @(posedge clk);
    #2;
    pulseOk = pulseOk && (rdValid === 1'b0);
  endtask
endmodule // sfr_host_model

// ==== tb/sfr_feedback_readback_tb.sv ====
`timescale 1ns/1ns
module sfr_feedback_readback_tb;
  import sfr_pkg::*;
  typedef struct packed {
    logic [1:0]  ch;
    logic        cal;
    logic        lay;
    logic [31:0] exp;
  } sfr_row_t;
  logic                         clk = 1'b0;
  logic                         rstn = 1'b0;
  logic                         calMode = 1'b0;
  logic                         layoutSelect = 1'b0;
  logic                         ditherEnable = 1'b0;
  logic [NumChannels-1:0]       channelActive = 3'h7;
  logic [NumChannels-1:0]       sampleValid = 3'h0;
  logic [NumChannels-1:0]       cycleEnd = 3'h0;
  logic [NumChannels-1:0]       ditherCycleEnd = 3'h0;
  logic [NumChannels-1:0][15:0] calCurrent = {16'h3c3c, 16'hb2b2, 16'h1234};
  logic [NumChannels-1:0][7:0]  currentSample = '0;
  logic [NumChannels-1:0][11:0] accumIn = '0;
  logic                         rdReq, rdValid, ok;
  logic [1:0]                   rdChannel;
  logic [31:0]                  rdData, word;
  int                           mismatches = 0;
  int                           n_compared = 0;
  sfr_row_t rows[7] = '{'{2'h0, 1'b1, 1'b0, 32'h4012_3400}, '{2'h1, 1'b1, 1'b0, 32'h41b2_b200},
                        '{2'h2, 1'b1, 1'b0, 32'h423c_3c00}, '{2'h3, 1'b1, 1'b0, 32'h4300_0000},
                        '{2'h3, 1'b0, 1'b1, 32'h4300_0000}, '{2'h0, 1'b0, 1'b0, 32'h4000_0000},
                        '{2'h0, 1'b1, 1'b1, 32'h4012_3400}};

  sfr_feedback_readback dut (.clk(clk), .rstn(rstn), .calMode(calMode),
    .layoutSelect(layoutSelect), .ditherEnable(ditherEnable), .channelActive(channelActive),
    .calCurrent(calCurrent), .sampleValid(sampleValid), .currentSample(currentSample),
    .cycleEnd(cycleEnd), .accumIn(accumIn), .ditherCycleEnd(ditherCycleEnd), .rdReq(rdReq),
    .rdChannel(rdChannel), .rdData(rdData), .rdValid(rdValid));
  sfr_host_model host (.clk(clk), .rdValid(rdValid), .rdData(rdData), .rdReq(rdReq),
    .rdChannel(rdChannel));

  always #10 clk = ~clk;
  ////////////////////////////////////////////////////////////////
  task automatic chk_word(input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask
  task automatic chk_bit(input logic exp, input logic got);
    chk_word({31'h0, exp}, {31'h0, got});
  endtask
  task automatic rd(input logic [1:0] ch, input logic [31:0] exp);
    host.read_word(ch, word, ok);
    chk_word(exp, word);
    chk_bit(1'b1, ok);
  endtask
  // Kind 0 sample, 1 switching cycle end, 2 dither cycle end
  task automatic strobe(input int kind, input int ch, input logic [7:0] v);
    @(posedge clk);
    #2;
    case (kind)
      0: begin
        sampleValid[ch] = 1'b1;
        currentSample[ch] = v;
      end
      1: cycleEnd[ch] = 1'b1;
      default: ditherCycleEnd[ch] = 1'b1;
    endcase
    @(posedge clk);
    #2;
    sampleValid = 3'h0;
    cycleEnd = 3'h0;
    ditherCycleEnd = 3'h0;
    currentSample[ch] = ~v;
  endtask
  task automatic stop_test;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  // Whole run is under two hundred clocks; this margin only catches a hang
  initial begin
    #(20 * 5000);
    mismatches++;
    stop_test();
  end
  initial begin
    repeat (20) @(posedge clk);
    chk_word(FeedbackReset, rdData);
    chk_bit(1'b0, rdValid);
    #2 rstn = 1'b1;
    $display("reset done");
    foreach (rows[i]) begin
      calMode = rows[i].cal;
      layoutSelect = rows[i].lay;
      rd(rows[i].ch, rows[i].exp);
    end
    $display("row table done");
    calMode = 1'b0;
    layoutSelect = 1'b0;
    accumIn[1] = 12'habc;
    strobe(1, 1, 8'h00);
    // Next end lands exactly 80 clocks later, five period units
    repeat (78) @(posedge clk);
    strobe(1, 1, 8'h00);
    rd(2'h1, 32'h41ab_c005);
    $display("period test done");
    layoutSelect = 1'b1;
    rd(2'h0, 32'h4000_ff00);
    strobe(0, 0, 8'h30);
    strobe(0, 0, 8'h90);
    strobe(0, 0, 8'h50);
    rd(2'h0, 32'h4090_3000);
    rd(2'h0, 32'h4000_ff00);
    $display("track test done");
    ditherEnable = 1'b1;
    strobe(2, 2, 8'h00);
    strobe(0, 2, 8'h20);
    strobe(0, 2, 8'h70);
    repeat (3) strobe(1, 2, 8'h00);
    strobe(2, 2, 8'h00);
    rd(2'h2, 32'h4270_2003);
    $display("dither test done");
    channelActive[2] = 1'b0;
    rd(2'h2, 32'h4200_0000);
    layoutSelect = 1'b0;
    rd(2'h2, 32'h4200_0000);
    // Word must stand unchanged while no read is taken
    repeat (4) @(posedge clk);
    #2;
    chk_word(32'h4200_0000, rdData);
    $display("idle test done");
    // Mid-run reset clears the held captures and restores the reset word
    rstn = 1'b0;
    @(posedge clk);
    #2;
    chk_word(FeedbackReset, rdData);
    chk_bit(1'b0, rdValid);
    rstn = 1'b1;
    rd(2'h1, 32'h4100_0000);
    $display("mid-run reset test done");
    stop_test();
  end
endmodule // sfr_feedback_readback_tb
